// [hw/lfg_params.svh]
// Purpose: Named offsets, reset values and timing for the fast gate block
// Assumes: 100 MHz block clock
// Notes:   Included by the package and the design module
`ifndef LFG_PARAMS_SVH
`define LFG_PARAMS_SVH

`define LFG_CLK_MHZ           100
`define LFG_LPC_PORT_ADDR     16'h0092
`define LFG_CFG_LDN           8'h01
`define LFG_CFG_IDX_ENABLE    8'h30
`define LFG_EC_BASE_RUNTIME   32'h400F_1800
`define LFG_EC_BASE_PRIVATE   32'h400F_1900
`define LFG_OFS_FAST_GATE     32'h0000_0000
`define LFG_OFS_ENABLE        32'h0000_0030
`define LFG_OFS_GATE_CTRL     32'h0000_0000
`define LFG_OFS_GATE_SET      32'h0000_0008
`define LFG_BIT_ENABLE        0
`define LFG_BIT_RESET         0
`define LFG_BIT_ALT_GATE      1
`define LFG_BIT_GATE_CTRL     0
`define LFG_RST_ENABLE        1'b0
`define LFG_RST_FAST_GATE     2'h0
`define LFG_RST_GATE_CTRL     1'b1
`define LFG_DELAY_US          14
`define LFG_PULSE_US          6
`define LFG_DELAY_CYC         (`LFG_DELAY_US * `LFG_CLK_MHZ)
`define LFG_PULSE_CYC         (`LFG_PULSE_US * `LFG_CLK_MHZ)
`define LFG_CNT_W             11

`endif

// [hw/lfg_pkg.sv]
// Purpose: Types for the fast gate and CPU reset block
// Assumes: lfg_params.svh supplies widths
// Notes:   Whole state lives in lfg_state_type
`include "lfg_params.svh"

package lfg_pkg;

  typedef enum logic [1:0]
  {
    LFG_IDLE  = 2'b00,
    LFG_DELAY = 2'b01,
    LFG_PULSE = 2'b10,
    LFG_WAIT0 = 2'b11
  } lfg_rst_state_type;

  // One register access port: write strobe, address, data
  typedef struct packed
  {
    logic        wr;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } lfg_ec_req_type;

  typedef struct packed
  {
    logic        cfg_wr;
    logic [7:0]  logical_device_number;
    logic [7:0]  index;
    logic        io_wr;
    logic [15:0] io_addr;
    logic [7:0]  wdata;
  } lfg_host_req_type;

  typedef struct packed
  {
    logic                   port_en;
    logic                   alt_gate;
    logic                   rst_bit;
    logic                   gate_ctrl;
    lfg_rst_state_type      rst_state;
    logic [`LFG_CNT_W-1:0]  count;
    logic                   pulse_n;
    logic [7:0]             host_rdata;
    logic [7:0]             ec_rdata;
  } lfg_state_type;

endpackage : lfg_pkg

// [hw/lfg_top.sv]
// Purpose: Fast address-line gate and fast CPU reset logic
// Assumes: Host and controller strobes are synchronous one-cycle pulses
// Notes:   Reads return data one cycle after the read strobe
`timescale 1ns/100ps
`include "lfg_params.svh"

// Functional notes
// - Host writes to port 92h are ignored unless the port enable bit is set.
// - The enable register is reached at logical device 1, index 30h.
// - The controller reaches the enable and port registers from 400F_1800h.
// - The gate output is the OR of the alternate level and controller bit.
// - Bit 1 of the port sets the alternate gate level high or low.
// - Writing 1 to bit 0 waits 14 us, then pulses reset low for 6 us.
// - A new pulse needs the reset bit written to 0 and then to 1 again.
// - The controller gate bit drives the gate and resets to 1.
// - Any write to the gate-set strobe at offset 08h sets the gate bit.
module lfg_top
  import lfg_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             reset_in,
  // Host side (LPC decoded cycles)
  input  wire lfg_host_req_type host_req_in,
  input  wire logic             host_cfg_rd_in,
  input  wire logic             host_io_rd_in,
  output logic      [7:0]       host_rdata_out,
  // Controller side
  input  wire lfg_ec_req_type   ec_req_in,
  input  wire logic             ec_rd_in,
  output logic      [7:0]       ec_rdata_out,
  // Outputs
  output logic                  address_line_gate_out,
  output logic                  alternate_reset_pulse_n_out
);

  lfg_state_type state;
  lfg_state_type next_state;

  logic cfg_hit;
  logic io_hit;
  logic ec_en_hit;
  logic ec_port_hit;
  logic ec_ctrl_hit;
  logic ec_set_hit;
  logic port_wr;
  logic [7:0] port_wdata;
  logic [7:0] enable_rd;
  logic [7:0] port_rd;
  logic [7:0] ctrl_rd;

  always_comb
  begin
    cfg_hit   = (host_req_in.logical_device_number == `LFG_CFG_LDN)
             && (host_req_in.index == `LFG_CFG_IDX_ENABLE);
    io_hit    = host_req_in.io_addr == `LFG_LPC_PORT_ADDR;
    ec_en_hit   = ec_req_in.addr
               == (`LFG_EC_BASE_RUNTIME + `LFG_OFS_ENABLE);
    ec_port_hit = ec_req_in.addr
               == (`LFG_EC_BASE_RUNTIME + `LFG_OFS_FAST_GATE);
    ec_ctrl_hit = ec_req_in.addr
               == (`LFG_EC_BASE_PRIVATE + `LFG_OFS_GATE_CTRL);
    ec_set_hit  = ec_req_in.addr
               == (`LFG_EC_BASE_PRIVATE + `LFG_OFS_GATE_SET);
    // Controller writes the port regardless; host only when enabled
    port_wr    = (host_req_in.io_wr && io_hit && state.port_en)
              || (ec_req_in.wr && ec_port_hit);
    port_wdata = (ec_req_in.wr && ec_port_hit) ? ec_req_in.wdata
                                                : host_req_in.wdata;
    enable_rd = {7'h00, state.port_en};
    port_rd   = {6'h00, state.alt_gate, state.rst_bit};
    ctrl_rd   = {7'h00, state.gate_ctrl};
  end

  always_comb
  begin
    next_state = state;
    // Enable register; controller write takes priority over host
    if (ec_req_in.wr && ec_en_hit)
    begin
      next_state.port_en = ec_req_in.wdata[`LFG_BIT_ENABLE];
    end
    else if (host_req_in.cfg_wr && cfg_hit)
    begin
      next_state.port_en = host_req_in.wdata[`LFG_BIT_ENABLE];
    end
    if (port_wr)
    begin
      next_state.alt_gate = port_wdata[`LFG_BIT_ALT_GATE];
      next_state.rst_bit  = port_wdata[`LFG_BIT_RESET];
    end
    if (ec_req_in.wr && ec_set_hit)
    begin
      next_state.gate_ctrl = 1'b1;
    end
    else if (ec_req_in.wr && ec_ctrl_hit)
    begin
      next_state.gate_ctrl = ec_req_in.wdata[`LFG_BIT_GATE_CTRL];
    end
    // Reset pulse sequencer
    next_state.pulse_n = 1'b1;
    unique case (state.rst_state)
      LFG_IDLE:
      begin
        if (port_wr && port_wdata[`LFG_BIT_RESET] && !state.rst_bit)
        begin
          next_state.rst_state = LFG_DELAY;
          next_state.count     = `LFG_CNT_W'(`LFG_DELAY_CYC - 1);
        end
      end
      LFG_DELAY:
      begin
        if (state.count == '0)
        begin
          next_state.rst_state = LFG_PULSE;
          next_state.count     = `LFG_CNT_W'(`LFG_PULSE_CYC - 1);
          next_state.pulse_n   = 1'b0;
        end
        else
        begin
          next_state.count = state.count - 1'b1;
        end
      end
      LFG_PULSE:
      begin
        next_state.pulse_n = 1'b0;
        if (state.count == '0)
        begin
          next_state.rst_state = LFG_WAIT0;
          next_state.pulse_n   = 1'b1;
        end
        else
        begin
          next_state.count = state.count - 1'b1;
        end
      end
      LFG_WAIT0:
      begin
        if (!next_state.rst_bit)
        begin
          next_state.rst_state = LFG_IDLE;
        end
      end
    endcase
    next_state.host_rdata = 8'h00;
    if (host_cfg_rd_in && cfg_hit)
    begin
      next_state.host_rdata = enable_rd;
    end
    else if (host_io_rd_in && io_hit)
    begin
      next_state.host_rdata = port_rd;
    end
    next_state.ec_rdata = 8'h00;
    if (ec_rd_in && ec_en_hit)
    begin
      next_state.ec_rdata = enable_rd;
    end
    else if (ec_rd_in && ec_port_hit)
    begin
      next_state.ec_rdata = port_rd;
    end
    else if (ec_rd_in && ec_ctrl_hit)
    begin
      next_state.ec_rdata = ctrl_rd;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      state           <= '0;
      state.port_en   <= `LFG_RST_ENABLE;
      state.alt_gate  <= 1'(`LFG_RST_FAST_GATE >> `LFG_BIT_ALT_GATE);
      state.rst_bit   <= 1'b0;
      state.gate_ctrl <= `LFG_RST_GATE_CTRL;
      state.rst_state <= LFG_IDLE;
      state.pulse_n   <= 1'b1;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign address_line_gate_out = state.alt_gate | state.gate_ctrl;
  assign alternate_reset_pulse_n_out = state.pulse_n;
  assign host_rdata_out = state.host_rdata;
  assign ec_rdata_out   = state.ec_rdata;

endmodule : lfg_top

// [dv/lfg_chk.sv]
// Purpose: Port assertions for lfg_top
// Assumes: One clock, sync reset
// Notes:   Bound to lfg_top below
`timescale 1ns/100ps
module lfg_chk
  import lfg_pkg::*;
(
  input wire logic             ref_clk_in,
  input wire logic             reset_in,
  input wire lfg_host_req_type host_req_in,
  input wire logic             host_cfg_rd_in,
  input wire logic             host_io_rd_in,
  input wire logic       [7:0] host_rdata_out,
  input wire lfg_ec_req_type   ec_req_in,
  input wire logic             ec_rd_in,
  input wire logic       [7:0] ec_rdata_out,
  input wire logic             address_line_gate_out,
  input wire logic             alternate_reset_pulse_n_out
);
  logic [11:0] lo_cnt;
  logic [11:0] dly_cnt;
  // Low time of the pulse and time since the last host I/O write with bit 0 set
  always_ff @(posedge ref_clk_in)
  begin
    lo_cnt  <= alternate_reset_pulse_n_out ? 12'h000 : lo_cnt + 12'h001;
    dly_cnt <= (host_req_in.io_wr && host_req_in.wdata[0]) ? 12'h000
               : dly_cnt + 12'h001;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_pulse_end;
    $rose(alternate_reset_pulse_n_out);
  endsequence
  sequence s_pulse_start;
    $fell(alternate_reset_pulse_n_out);
  endsequence
  property p_width;
    s_pulse_end |-> lo_cnt inside {[600:601]};
  endproperty
  a_width: assert property (p_width) else $error("pulse width");
  property p_delay;
    s_pulse_start |-> dly_cnt inside {[1399:1402]};
  endproperty
  a_delay: assert property (p_delay) else $error("pulse delay");
  property p_rd_idle;
    !$past(host_cfg_rd_in || host_io_rd_in) |-> host_rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("idle data");
  property p_ec_rsv;
    ec_rdata_out[7:2] == 6'h00;
  endproperty
  a_ec_rsv: assert property (p_ec_rsv) else $error("reserved bits");
  property p_set;
    ec_req_in.wr && ec_req_in.addr == 32'h400F_1908
      |=> address_line_gate_out;
  endproperty
  a_set: assert property (p_set) else $error("gate set");
  property p_cfg;
    host_cfg_rd_in && host_req_in.logical_device_number == 8'h01 && host_req_in.index == 8'h30
      |=> host_rdata_out[7:1] == 7'h00;
  endproperty
  a_cfg: assert property (p_cfg) else $error("enable read");
  property p_hold;
    !(ec_req_in.wr || host_req_in.io_wr) |=> $stable(address_line_gate_out);
  endproperty
  a_hold: assert property (p_hold) else $error("gate moved");
  property p_gate_rst;
    $fell(reset_in) |-> address_line_gate_out;
  endproperty
  a_gate_rst: assert property (p_gate_rst) else $error("gate reset");
endmodule : lfg_chk

bind lfg_top lfg_chk u_chk (.ref_clk_in, .reset_in, .host_req_in,
  .host_cfg_rd_in, .host_io_rd_in, .host_rdata_out, .ec_req_in, .ec_rd_in,
  .ec_rdata_out, .address_line_gate_out, .alternate_reset_pulse_n_out);

// [dv/lfg_cpu_model.sv]
// Purpose: CPU side that counts alternate reset pulses
// Assumes: Pulse is active low
// Notes:   Listens only
`timescale 1ns/100ps
module lfg_cpu_model
(
  input  wire logic       cpu_reset_n_in,
  output logic      [3:0] resets_seen_out
);
  initial resets_seen_out = 4'h0;
  always @(negedge cpu_reset_n_in)
    resets_seen_out <= resets_seen_out + 4'h1;
endmodule : lfg_cpu_model

// [dv/lfg_top_tb.sv]
// Purpose: Register-level tests for lfg_top
// Assumes: Inputs change on the falling edge
// Notes:   Pulse timing is judged by lfg_chk
`timescale 1ns/100ps
module lfg_top_tb import lfg_pkg::*;;
  logic             ref_clk_in = 1'b0;
  logic             reset_in = 1'b1;
  lfg_host_req_type host_req_in = '0;
  logic             host_cfg_rd_in = 1'b0;
  logic             host_io_rd_in = 1'b0;
  lfg_ec_req_type   ec_req_in = '0;
  logic             ec_rd_in = 1'b0;
  logic       [7:0] host_rdata_out;
  logic       [7:0] ec_rdata_out;
  logic             address_line_gate_out;
  logic             alternate_reset_pulse_n_out;
  logic       [3:0] seen;
  logic       [7:0] v;
  int               error_cnt = 0;
  int               total_checks = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  lfg_top dut (.ref_clk_in, .reset_in, .host_req_in, .host_cfg_rd_in,
    .host_io_rd_in, .host_rdata_out, .ec_req_in, .ec_rd_in, .ec_rdata_out,
    .address_line_gate_out, .alternate_reset_pulse_n_out);
  lfg_cpu_model cpu (.cpu_reset_n_in(alternate_reset_pulse_n_out),
    .resets_seen_out(seen));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Kind 0 host I/O, 1 controller, 2 host config (ldn in a[15:8])
  task wr(input logic [1:0] k, input logic [31:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    {host_req_in.logical_device_number, host_req_in.index} = a[15:0];
    host_req_in.io_addr = a[15:0];
    ec_req_in.addr = a;
    host_req_in.wdata = d;
    ec_req_in.wdata = d;
    host_req_in.io_wr = (k == 2'h0);
    ec_req_in.wr = (k == 2'h1);
    host_req_in.cfg_wr = (k == 2'h2);
    @(negedge ref_clk_in);
    host_req_in.io_wr = 1'b0;
    ec_req_in.wr = 1'b0;
    host_req_in.cfg_wr = 1'b0;
  endtask : wr
  // Kind 0 host I/O, 1 controller, 2 host config (ldn in a[15:8])
  task rd(input logic [1:0] k, input logic [31:0] a);
    @(negedge ref_clk_in);
    ec_req_in.addr = a;
    host_req_in.io_addr = a[15:0];
    {host_req_in.logical_device_number, host_req_in.index} = a[15:0];
    ec_rd_in = (k == 2'h1);
    host_io_rd_in = (k == 2'h0);
    host_cfg_rd_in = (k == 2'h2);
    @(negedge ref_clk_in);
    ec_rd_in = 1'b0;
    host_io_rd_in = 1'b0;
    host_cfg_rd_in = 1'b0;
    v = (k == 2'h1) ? ec_rdata_out : host_rdata_out;
  endtask : rd
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #200us;
    error_cnt++;
    report_and_stop;
  end
  initial
  begin
    repeat (8) @(negedge ref_clk_in);
    reset_in = 1'b0;
    rd(2'h1, 32'h400F_1900);
    chk("gate_control", 8'h01, v);
    rd(2'h1, 32'h400F_1830);
    chk("enable", 8'h00, v);
    wr(2'h1, 32'h400F_1900, 8'h00);
    chk("gate", 8'h00, {7'h00, address_line_gate_out});
    wr(2'h2, 32'h0000_0131, 8'hFF);
    wr(2'h0, 32'h0000_0092, 8'h02);
    chk("gate", 8'h00, {7'h00, address_line_gate_out});
    wr(2'h2, 32'h0000_0130, 8'hFF);
    rd(2'h1, 32'h400F_1830);
    chk("enable", 8'h01, v);
    rd(2'h2, 32'h0000_0130);
    chk("enable_cfg", 8'h01, v);
    wr(2'h0, 32'h0000_0092, 8'h02);
    chk("gate", 8'h01, {7'h00, address_line_gate_out});
    rd(2'h0, 32'h0000_0092);
    chk("port", 8'h02, v);
    wr(2'h0, 32'h0000_0092, 8'h00);
    chk("gate", 8'h00, {7'h00, address_line_gate_out});
    wr(2'h1, 32'h400F_1800, 8'h02);
    chk("gate", 8'h01, {7'h00, address_line_gate_out});
    wr(2'h1, 32'h400F_1800, 8'h00);
    chk("gate", 8'h00, {7'h00, address_line_gate_out});
    wr(2'h1, 32'h400F_1908, 8'h5A);
    rd(2'h1, 32'h400F_1900);
    chk("gate_control", 8'h01, v);
    rd(2'h1, 32'h400F_1904);
    chk("unmapped", 8'h00, v);
    wr(2'h0, 32'h0000_0092, 8'h01);
    repeat (2100) @(negedge ref_clk_in);
    chk("pulses", 8'h01, {4'h0, seen});
    wr(2'h0, 32'h0000_0092, 8'h01);
    repeat (2100) @(negedge ref_clk_in);
    chk("pulses", 8'h01, {4'h0, seen});
    wr(2'h0, 32'h0000_0092, 8'h00);
    wr(2'h0, 32'h0000_0092, 8'h01);
    repeat (2100) @(negedge ref_clk_in);
    chk("pulses", 8'h02, {4'h0, seen});
    report_and_stop;
  end
endmodule : lfg_top_tb
